// ==== src/sisf_status_flags.sv ====
// sisf_status_flags.sv: event status flags, enables and combined request behind an apb slave
//
// Design decision made here: register access over APB.
`include "sisf_consts.svh"

// What this block does
// - set almost-full flag, bit 7, when the next sample would pass the threshold.
// - almost-full clears on main status read, or fifo data read when enabled.
// - set new-sample flag, bit 6, whenever fresh data enters the fifo.
// - new-sample clears on main status read, or fifo data read when enabled.
// - set ambient-cancel overflow flag, bit 5, when cancellation hits its limit.
// - ambient-cancel overflow clears only by reading the main status register.
// - set proximity flag, bit 4, on first exposure crossing; main status read clears.
// - proximity enable at 0 skips the proximity phase and starts the sequence at once.
// - at sample end, noncompliant driver with enable 1 sets bit 3; status read clears.
// - set temperature-done flag, bit 2, when a temperature conversion completes.
// - temperature-done clears on temperature result read or main status read.
// - supply out of range for 10 ms sets bit 1, repeating while it persists.
// - supply-out-of-range flag clears on each main status read that returns it set.
// - power-loss flag, bit 0, marks undervoltage lockout; soft reset never sets it.
// - power-loss clears on main status read or writing 1 to shutdown control.
// - set authentication-done flag, bit 0 of aux status, when hashing completes.
// - authentication-done clears on aux status read; bits 7 to 1 read zero.
// - status flags are read-only, reset to zero, and ignore host writes.
// - a flag requests an interrupt only when its enable bit is 1.
module sisf_status_flags #(
    parameter int OOR_QUAL_CYCLES = `SISF_OOR_QUAL_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        sample_push,
    input  wire logic [7:0]  fifo_level,
    input  wire logic [6:0]  almost_full_threshold,
    input  wire logic        fifo_data_read,
    input  wire logic        ambient_cancel_overflow_event,
    input  wire logic        first_exposure_valid,
    input  wire logic [18:0] first_exposure_result,
    input  wire logic [7:0]  prox_threshold,
    input  wire logic        sample_end,
    input  wire logic        led_noncompliant,
    input  wire logic        temp_conversion_done,
    input  wire logic        temp_result_read,
    input  wire logic        supply_above_range,
    input  wire logic        supply_below_range,
    input  wire logic        undervoltage_lockout_event,
    input  wire logic        auth_done_event,
    output logic             irq,
    output logic             prox_phase_skip,
    output logic             shutdown_control,
    output logic             clear_status_on_fifo_read
);

    // ------------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------------
    localparam logic [19:0] OOR_LAST = 20'(OOR_QUAL_CYCLES - 1);

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function automatic logic sisf_hit(input logic [11:0] addr, input logic [9:0] idx);
        sisf_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
    endfunction : sisf_hit

    function automatic logic sisf_mapped(input logic [11:0] addr);
        sisf_mapped = sisf_hit(addr, `SISF_IDX_EVENT_STATUS_MAIN)
                   || sisf_hit(addr, `SISF_IDX_EVENT_STATUS_AUX)
                   || sisf_hit(addr, `SISF_IDX_EVENT_ENABLE_MAIN)
                   || sisf_hit(addr, `SISF_IDX_EVENT_ENABLE_AUX)
                   || sisf_hit(addr, `SISF_IDX_STATUS_CONTROL);
    endfunction : sisf_mapped

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    sisf_pkg::sisf_state_s state_reg;
    sisf_pkg::sisf_state_s state_next;

    logic       access_first;
    logic       access_done;
    logic       read_clear;
    logic       write_ok;
    logic [7:0] read_value;
    logic [7:0] main_set;
    logic [7:0] main_clr;
    logic       aux_set;
    logic       aux_clr;
    logic       reading_below;
    logic       prox_set;
    logic       supply_bad;
    logic       oor_set;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        read_value    = 8'h00;
        main_set      = 8'h00;
        main_clr      = 8'h00;
        aux_set       = 1'b0;
        aux_clr       = 1'b0;
        prox_set      = 1'b0;
        oor_set       = 1'b0;

        // one wait state: the read value is latched in the first access cycle
        // so pready and prdata come from flops
        access_first = psel && penable && !state_reg.pready;
        access_done  = psel && penable && state_reg.pready;
        read_clear   = access_done && !pwrite && !state_reg.pslverr;
        write_ok     = access_done && pwrite && !state_reg.pslverr && pstrb[0];

        if (sisf_hit(paddr, `SISF_IDX_EVENT_STATUS_MAIN)) begin
            read_value = state_reg.status_main;
        end else if (sisf_hit(paddr, `SISF_IDX_EVENT_STATUS_AUX)) begin
            read_value = {7'h00, state_reg.status_aux[`SISF_BIT_AUTH_DONE]};
        end else if (sisf_hit(paddr, `SISF_IDX_EVENT_ENABLE_MAIN)) begin
            read_value = state_reg.enable_main;
        end else if (sisf_hit(paddr, `SISF_IDX_EVENT_ENABLE_AUX)) begin
            read_value = state_reg.enable_aux;
        end else if (sisf_hit(paddr, `SISF_IDX_STATUS_CONTROL)) begin
            read_value = {6'h00, state_reg.shutdown_control,
                          state_reg.clear_status_on_fifo_read};
        end else begin
            read_value = 8'h00;
        end

        if (access_first) begin
            state_next.pready  = 1'b1;
            state_next.prdata  = {24'h00_0000, read_value};
            state_next.pslverr = !sisf_mapped(paddr);
        end else begin
            state_next.pready  = 1'b0;
            state_next.pslverr = 1'b0;
        end

        // --------------------------------------------------------------------
        // register writes; status registers take no write at all
        // --------------------------------------------------------------------
        if (write_ok) begin
            if (sisf_hit(paddr, `SISF_IDX_EVENT_ENABLE_MAIN)) begin
                state_next.enable_main = pwdata[7:0] & `SISF_ENABLE_MAIN_MASK;
            end else if (sisf_hit(paddr, `SISF_IDX_EVENT_ENABLE_AUX)) begin
                state_next.enable_aux = pwdata[7:0] & `SISF_ENABLE_AUX_MASK;
            end else if (sisf_hit(paddr, `SISF_IDX_STATUS_CONTROL)) begin
                state_next.clear_status_on_fifo_read = pwdata[`SISF_BIT_CLR_ON_FIFO_READ];
                state_next.shutdown_control          = pwdata[`SISF_BIT_SHUTDOWN];
                if (pwdata[`SISF_BIT_SHUTDOWN]) begin
                    main_clr[`SISF_BIT_POWER_LOSS] = 1'b1;
                end
            end
        end

        // --------------------------------------------------------------------
        // clearing reads: a status read clears only the bits the host actually saw; fifo and temperature reads clear theirs outright
        // --------------------------------------------------------------------
        if (read_clear && sisf_hit(paddr, `SISF_IDX_EVENT_STATUS_MAIN)) begin
            // covers almost-full, new-sample, ambient, proximity, led,
            // temperature, supply and power-loss flags
            main_clr = main_clr | state_reg.prdata[7:0];
        end
        if (read_clear && sisf_hit(paddr, `SISF_IDX_EVENT_STATUS_AUX)) begin
            aux_clr = state_reg.prdata[`SISF_BIT_AUTH_DONE];
        end
        if (fifo_data_read && state_reg.clear_status_on_fifo_read) begin
            main_clr[`SISF_BIT_ALMOST_FULL] = 1'b1;
            main_clr[`SISF_BIT_NEW_SAMPLE]  = 1'b1;
        end
        if (temp_result_read) begin
            main_clr[`SISF_BIT_TEMP_DONE] = 1'b1;
        end

        // --------------------------------------------------------------------
        // proximity tracking
        // --------------------------------------------------------------------
        reading_below = first_exposure_result <
                        {prox_threshold, {`SISF_PROX_SCALE_SHIFT{1'b0}}};
        case (state_reg.prox_state)
            sisf_pkg::SISF_PROX_OFF: begin
                if (state_reg.enable_main[`SISF_BIT_PROXIMITY] && first_exposure_valid) begin
                    prox_set = 1'b1;
                    state_next.prox_state = reading_below ? sisf_pkg::SISF_PROX_NEAR
                                                          : sisf_pkg::SISF_PROX_NORMAL;
                end
            end
            sisf_pkg::SISF_PROX_NEAR: begin
                if (first_exposure_valid && !reading_below) begin
                    prox_set = 1'b1;
                    state_next.prox_state = sisf_pkg::SISF_PROX_NORMAL;
                end
            end
            sisf_pkg::SISF_PROX_NORMAL: begin
                if (first_exposure_valid && reading_below) begin
                    prox_set = 1'b1;
                    state_next.prox_state = sisf_pkg::SISF_PROX_NEAR;
                end
            end
            default: begin
                state_next.prox_state = sisf_pkg::SISF_PROX_OFF;
            end
        endcase
        if (!state_reg.enable_main[`SISF_BIT_PROXIMITY]) begin
            // disabled tracking forgets its mode, so re-enabling reports afresh
            state_next.prox_state = sisf_pkg::SISF_PROX_OFF;
            prox_set = 1'b0;
        end
        state_next.prox_phase_skip = !state_next.enable_main[`SISF_BIT_PROXIMITY];

        // --------------------------------------------------------------------
        // supply qualification: restarts after each report so the flag
        // keeps coming back while the supply stays bad
        // --------------------------------------------------------------------
        supply_bad = supply_above_range || supply_below_range;
        if (!supply_bad) begin
            state_next.oor_count = 20'h0_0000;
        end else if (state_reg.oor_count >= OOR_LAST) begin
            oor_set = 1'b1;
            state_next.oor_count = 20'h0_0000;
        end else begin
            state_next.oor_count = state_reg.oor_count + 20'h0_0001;
        end

        // --------------------------------------------------------------------
        // event sources
        // --------------------------------------------------------------------
        if (sample_push && ({1'b0, fifo_level} + 9'h001 > {2'b00, almost_full_threshold})) begin
            main_set[`SISF_BIT_ALMOST_FULL] = 1'b1;
        end
        main_set[`SISF_BIT_NEW_SAMPLE]  = sample_push;
        main_set[`SISF_BIT_AMBIENT_OVF] = ambient_cancel_overflow_event;
        main_set[`SISF_BIT_PROXIMITY]   = prox_set;
        main_set[`SISF_BIT_LED_NONCOMPLIANT] = sample_end && led_noncompliant
                               && state_reg.enable_main[`SISF_BIT_LED_NONCOMPLIANT];
        main_set[`SISF_BIT_TEMP_DONE]   = temp_conversion_done;
        main_set[`SISF_BIT_SUPPLY_OOR]  = oor_set;
        // soft reset is not an input here, so it cannot raise this flag
        main_set[`SISF_BIT_POWER_LOSS]  = undervoltage_lockout_event;
        aux_set = auth_done_event;

        // set wins over clear so an event in the clearing cycle survives
        state_next.status_main = (state_reg.status_main & ~main_clr) | main_set;
        state_next.status_aux  = {7'h00,
                                  (state_reg.status_aux[`SISF_BIT_AUTH_DONE] && !aux_clr)
                                  || aux_set};

        // --------------------------------------------------------------------
        // combined request from the next flag values, so irq is a flop
        // --------------------------------------------------------------------
        state_next.irq = |(state_next.status_main & state_next.enable_main)
                      || |(state_next.status_aux & state_next.enable_aux);
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign pready                    = state_reg.pready;
    assign prdata                    = state_reg.prdata;
    assign pslverr                   = state_reg.pslverr;
    assign irq                       = state_reg.irq;
    assign prox_phase_skip           = state_reg.prox_phase_skip;
    assign shutdown_control          = state_reg.shutdown_control;
    assign clear_status_on_fifo_read = state_reg.clear_status_on_fifo_read;

endmodule : sisf_status_flags

// ==== common/sisf_consts.svh ====
// sisf_consts.svh: offsets, field positions, reset values and timing counts of the status flags
`ifndef SISF_CONSTS_SVH
`define SISF_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SISF_IDX_EVENT_STATUS_MAIN 10'h000
`define SISF_IDX_EVENT_STATUS_AUX  10'h001
`define SISF_IDX_EVENT_ENABLE_MAIN 10'h002
`define SISF_IDX_EVENT_ENABLE_AUX  10'h003
`define SISF_IDX_STATUS_CONTROL    10'h010

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SISF_BIT_ALMOST_FULL       7
`define SISF_BIT_NEW_SAMPLE        6
`define SISF_BIT_AMBIENT_OVF       5
`define SISF_BIT_PROXIMITY         4
`define SISF_BIT_LED_NONCOMPLIANT  3
`define SISF_BIT_TEMP_DONE         2
`define SISF_BIT_SUPPLY_OOR        1
`define SISF_BIT_POWER_LOSS        0
`define SISF_BIT_AUTH_DONE         0
`define SISF_BIT_CLR_ON_FIFO_READ  0
`define SISF_BIT_SHUTDOWN          1

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define SISF_STATUS_RESET          8'h00
`define SISF_ENABLE_MAIN_MASK      8'hfe
`define SISF_ENABLE_AUX_MASK       8'h01
`define SISF_CONTROL_MASK          8'h03

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SISF_CLK_PERIOD_NS         10
`define SISF_OOR_QUAL_MS           10
`define SISF_OOR_QUAL_CYCLES       ((`SISF_OOR_QUAL_MS * 1000000) / `SISF_CLK_PERIOD_NS)
`define SISF_PROX_SCALE_SHIFT      11

`endif

// ==== common/sisf_pkg.sv ====
// sisf_pkg.sv: types of the sensor interrupt status flag block
package sisf_pkg;

    // ------------------------------------------------------------------------
    // proximity tracking states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SISF_PROX_OFF    = 2'b00,
        SISF_PROX_NEAR   = 2'b01,
        SISF_PROX_NORMAL = 2'b10
    } sisf_prox_e;

    // ------------------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  status_main;
        logic [7:0]  status_aux;
        logic [7:0]  enable_main;
        logic [7:0]  enable_aux;
        logic        clear_status_on_fifo_read;
        logic        shutdown_control;
        sisf_prox_e  prox_state;
        logic [19:0] oor_count;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
        logic        prox_phase_skip;
    } sisf_state_s;

endpackage : sisf_pkg

// ==== sim/sisf_host_model.sv ====
// sisf_host_model.sv: apb host processor model reaching the status flag registers
module sisf_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end
    // released address and data lines show the inverse of the last value so a stale bus cannot pass
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'h1};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
        #1;
    endtask : xfer
endmodule : sisf_host_model

// ==== sim/sisf_status_flags_properties.sv ====
// sisf_status_flags_properties.sv: port-level assertions of the status flag block
module sisf_status_flags_properties #(
    parameter int OOR_QUAL_CYCLES = 20
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        prox_phase_skip,
    input wire logic        shutdown_control
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic done_now;
    logic mapped;
    assign done_now = psel && penable && pready && clk_en;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h040};
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready stood over one cycle");
    property p_ready_wait; pready |-> psel && penable && $past(penable); endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready without a wait state");
    property p_high_zero; pready |-> prdata[31:8] == 24'h00_0000; endproperty
    a_high_zero: assert property (p_high_zero) else $error("read data above byte");
    property p_aux_unused; pready && !pwrite && paddr == 12'h004 |-> prdata[7:1] == 0;
    endproperty
    a_aux_unused: assert property (p_aux_unused) else $error("aux spare bits set");
    property p_err_map; pready |-> pslverr == !mapped && (mapped || prdata == 0); endproperty
    a_err_map: assert property (p_err_map) else $error("error response wrong for address");
    // enable and control copies change on the completing edge, yet they are judged two edges on
    property p_skip_follow;
        logic b;
        (done_now && pwrite && paddr == 12'h008 && pstrb[0], b = pwdata[4]) |->
            ##2 prox_phase_skip == !b;
    endproperty
    a_skip_follow: assert property (p_skip_follow) else $error("skip flag wrong");
    property p_ctrl_follow;
        logic b;
        (done_now && pwrite && paddr == 12'h040 && pstrb[0], b = pwdata[1]) |->
            ##2 shutdown_control == b;
    endproperty
    a_ctrl_follow: assert property (p_ctrl_follow) else $error("shutdown copy wrong");
    property p_rst_quiet; $rose(presetn) |-> !irq && !pready && !shutdown_control; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule : sisf_status_flags_properties
bind sisf_status_flags sisf_status_flags_properties #(.OOR_QUAL_CYCLES(OOR_QUAL_CYCLES)) i_props (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .irq, .prox_phase_skip, .shutdown_control);

// ==== sim/testbench.sv ====
// testbench.sv: self-checking bench of the status flag block against fixed expected values
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic        prox_phase_skip, shutdown_control, clear_status_on_fifo_read, clk_en;
    logic        supply_above_range, supply_below_range, led_noncompliant;
    logic [3:0]  pstrb;
    logic [6:0]  almost_full_threshold;
    logic [7:0]  fifo_level, prox_threshold;
    logic [8:0]  ev;
    logic [11:0] paddr;
    logic [18:0] first_exposure_result;
    logic [31:0] pwdata, prdata, r, lf;
    int          error_cnt, compares, sm, em;
    sisf_status_flags #(.OOR_QUAL_CYCLES(20)) i_sisf_status_flags (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .sample_push(ev[0]), .fifo_level, .almost_full_threshold,
        .fifo_data_read(ev[7]), .ambient_cancel_overflow_event(ev[1]),
        .first_exposure_valid(ev[2]), .first_exposure_result, .prox_threshold,
        .sample_end(ev[3]), .led_noncompliant, .temp_conversion_done(ev[4]),
        .temp_result_read(ev[8]), .supply_above_range, .supply_below_range,
        .undervoltage_lockout_event(ev[5]), .auth_done_event(ev[6]), .irq,
        .prox_phase_skip, .shutdown_control, .clear_status_on_fifo_read);
    sisf_host_model i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                            .pready, .prdata, .pslverr);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        close_out();
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, r, e);
    endtask : wr
    // event inputs are one-cycle pulses launched on an edge
    task automatic fire(input int k);
        @(posedge pclk);
        ev <= 9'h001 << k;
        @(posedge pclk);
        ev <= 9'h000;
        #1;
    endtask : fire
    task automatic close_out();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    initial begin
        {presetn, ev, fifo_level, almost_full_threshold, supply_above_range} = '0;
        {supply_below_range, first_exposure_result} = '0;
        {clk_en, led_noncompliant, prox_threshold, lf} = {2'b11, 8'h01, 32'h0000_2b64};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++) rd(a == 4 ? 12'h040 : 12'(a * 4), 0);
        chk(prox_phase_skip, 1);
        lf = nxt(lf);
        wr(12'h000, lf);
        wr(12'h004, lf);
        fire(2);
        rd(12'h000, 0);
        rd(12'h004, 0);
        i_host.xfer(1'b0, 12'h0fc, 32'h0000_0000, r, e);
        chk(e, 1);
        chk(r, 0);
        $display("test reset and access done");
        wr(12'h008, 32'h0000_00ff);
        wr(12'h00c, 32'h0000_0001);
        em = 32'h0000_00fe;
        rd(12'h008, em);
        chk(prox_phase_skip, 0);
        repeat (6) begin
            lf = nxt(lf);
            @(posedge pclk);
            {almost_full_threshold, fifo_level} <= {lf[6:0], 1'b0, lf[14:8]};
            fire(0);
            sm = (int'(lf[14:8]) + 1 > int'(lf[6:0])) ? 32'h0000_00c0 : 32'h0000_0040;
            chk(irq, 1);
            rd(12'h000, sm);
            chk(irq, 0);
        end
        for (int k = 1; k < 6; k++) begin
            fire(k);
            sm = (k == 5) ? 1 : (32'h0000_0040 >> k);
            chk(irq, k != 5);
            rd(12'h000, sm);
            rd(12'h000, 0);
        end
        fire(2);
        rd(12'h000, 0);
        @(posedge pclk);
        first_exposure_result <= 19'h7_ffff;
        fire(2);
        rd(12'h000, 32'h0000_0010);
        $display("test flag set and read clear done");
        fire(4);
        fire(8);
        chk(irq, 0);
        fire(5);
        wr(12'h040, 32'h0000_0002);
        rd(12'h000, 0);
        chk(shutdown_control, 1);
        wr(12'h040, 32'h0000_0001);
        @(posedge pclk);
        {almost_full_threshold, fifo_level} <= {7'h00, 8'h7f};
        fire(0);
        chk(clear_status_on_fifo_read, 1);
        fire(1);
        fire(7);
        rd(12'h000, 32'h0000_0020);
        wr(12'h040, 32'h0000_0000);
        fire(0);
        fire(7);
        rd(12'h000, 32'h0000_00c0);
        $display("test clear paths done");
        @(posedge pclk);
        supply_above_range <= 1'b1;
        repeat (25) @(posedge pclk);
        rd(12'h000, 32'h0000_0002);
        repeat (25) @(posedge pclk);
        supply_above_range <= 1'b0;
        rd(12'h000, 32'h0000_0002);
        @(posedge pclk);
        supply_below_range <= 1'b1;
        repeat (10) @(posedge pclk);
        supply_below_range <= 1'b0;
        rd(12'h000, 0);
        wr(12'h008, 32'h0000_00e7);
        fire(3);
        fire(2);
        chk(prox_phase_skip, 1);
        rd(12'h000, 0);
        $display("test supply and enables done");
        fire(6);
        chk(irq, 1);
        rd(12'h004, 1);
        fork
            rd(12'h004, 0);
            begin
                repeat (3) @(posedge pclk);
                ev <= 9'h040;
                @(posedge pclk);
                ev <= 9'h000;
            end
        join
        wr(12'h00c, 32'h0000_0000);
        chk(irq, 0);
        rd(12'h004, 1);
        $display("test auth flag done");
        // a frozen block must drop events instead of banking them for later
        @(posedge pclk);
        clk_en <= 1'b0;
        fire(1);
        fire(4);
        @(posedge pclk);
        clk_en <= 1'b1;
        rd(12'h000, 0);
        chk(irq, 0);
        fire(1);
        rd(12'h000, 32'h0000_0020);
        $display("test clock enable done");
        close_out();
    end
endmodule : testbench
